/* design/lcr_pkg.sv */
// Shared widths, types and reset values of the lane clock and reset block
package lcr_pkg;

  // Lane geometry
  localparam int unsigned LANE_COUNT = 12;
  localparam int unsigned WORD_W     = 64;
  localparam int unsigned LANE_IDX_W = 4;
  localparam int unsigned RX_ITEM_W  = LANE_IDX_W + WORD_W;

  // Bit order inside a lane word: first bit on the line, last bit
  localparam int unsigned WORD_FIRST_BIT = 63;
  localparam int unsigned WORD_LAST_BIT  = 0;

  typedef logic [WORD_W-1:0]                  lcr_word_t;
  typedef logic [LANE_COUNT-1:0][WORD_W-1:0]  lcr_lanes_t;
  typedef logic [LANE_COUNT-1:0]              lcr_mask_t;
  typedef logic [LANE_IDX_W-1:0]              lcr_idx_t;
  typedef logic [RX_ITEM_W-1:0]               lcr_item_t;

  // Reset values
  localparam lcr_word_t  TX_IDLE_WORD   = 64'h0000000000000000;
  localparam lcr_lanes_t LANES_RESET    = '0;
  localparam lcr_mask_t  MASK_RESET     = 12'h000;
  localparam lcr_mask_t  MASK_SET       = 12'hFFF;
  localparam logic [1:0] RST_SYNC_INIT  = 2'h3;
  localparam logic [1:0] RST_SYNC_CLEAR = 2'h0;

endpackage

/* design/lcr_lane_if.sv */
// Lane clock and reset interface: lane word capture, transmit drive, syncs
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Two-entry buffer; every output is a flip-flop
module lcr_buf2 #(
  parameter int unsigned W = 8
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         flush_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  logic         head_v_q, head_v_d, tail_v_q, tail_v_d, rdy_q, rdy_d;
  logic [W-1:0] head_q, head_d, tail_q, tail_d;
  logic         push, pop;

  // Tail catches a word when the drain stalls, so nothing is dropped
  always_comb begin
    push     = in_valid_i & rdy_q;
    pop      = head_v_q & out_ready_i;
    head_v_d = head_v_q;
    head_d   = head_q;
    tail_v_d = tail_v_q;
    tail_d   = tail_q;
    if (pop || !head_v_q) begin
      if (tail_v_q) begin
        head_v_d = 1'b1;
        head_d   = tail_q;
        tail_v_d = 1'b0;
      end else begin
        head_v_d = push;
        head_d   = push ? in_data_i : head_q;
      end
    end else if (push) begin
      tail_v_d = 1'b1;
      tail_d   = in_data_i;
    end
    if (flush_i) begin
      head_v_d = 1'b0;
      tail_v_d = 1'b0;
    end
    rdy_d = ~tail_v_d;
  end

  // Buffer registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
      rdy_q    <= 1'b1;
      head_q   <= '0;
      tail_q   <= '0;
    end else begin
      head_v_q <= head_v_d;
      tail_v_q <= tail_v_d;
      rdy_q    <= rdy_d;
      head_q   <= head_d;
      tail_q   <= tail_d;
    end
  end

  assign in_ready_o  = rdy_q;
  assign out_valid_o = head_v_q;
  assign out_data_o  = head_q;
endmodule

////////////////////////////////////////////////////////////////////////////////
// Top: all foreign clocks are sampled by core_clk_i and used as enables
module lcr_lane_if (
  // Core clock and reset
  input  wire logic                 core_clk_i,
  input  wire logic                 rst_i,
  // Path resets, asynchronous, active high
  input  wire logic                 rx_path_reset_i,
  input  wire logic                 tx_path_reset_i,
  // Foreign clocks and their resets
  input  wire logic                 user_bus_clock_i,
  input  wire logic                 tx_reference_clock_i,
  input  wire logic                 tx_reference_clock_reset_i,
  input  wire lcr_pkg::lcr_mask_t   rx_lane_recovered_clock_i,
  input  wire lcr_pkg::lcr_mask_t   rx_lane_reset_i,
  // Receive lane words
  input  wire lcr_pkg::lcr_lanes_t  rx_lane_word_i,
  // Transmit lane words
  output lcr_pkg::lcr_lanes_t       tx_lane_word_o,
  output logic                      tx_lane_strobe_o,
  // User transmit group
  input  wire logic                 tx_valid_i,
  output logic                      tx_ready_o,
  input  wire lcr_pkg::lcr_lanes_t  tx_group_i,
  // User receive stream
  output logic                      rx_valid_o,
  input  wire logic                 rx_ready_i,
  output lcr_pkg::lcr_idx_t         rx_lane_o,
  output lcr_pkg::lcr_word_t        rx_word_o,
  // Status
  output logic                      rx_overflow_o,
  output lcr_pkg::lcr_mask_t        rx_lane_active_o,
  output logic                      rx_path_in_reset_o,
  output logic                      tx_path_in_reset_o
);
  import lcr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Path reset synchronisers: assert at once, release after two core edges
  logic [1:0] rx_rst_q, tx_rst_q;
  logic       rx_rst_any, tx_rst_any, rx_rst_s, tx_rst_s;

  assign rx_rst_any = rst_i | rx_path_reset_i;
  assign tx_rst_any = rst_i | tx_path_reset_i;

  // Receive path reset into the core domain
  always_ff @(posedge core_clk_i or posedge rx_rst_any) begin
    if (rx_rst_any) begin
      rx_rst_q <= RST_SYNC_INIT;
    end else begin
      rx_rst_q <= {rx_rst_q[0], 1'b0};
    end
  end

  // Transmit path reset into the core domain
  always_ff @(posedge core_clk_i or posedge tx_rst_any) begin
    if (tx_rst_any) begin
      tx_rst_q <= RST_SYNC_INIT;
    end else begin
      tx_rst_q <= {tx_rst_q[0], 1'b0};
    end
  end

  assign rx_rst_s = rx_rst_q[1];
  assign tx_rst_s = tx_rst_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // Two-flop samplers for the foreign clocks, lane resets, lane words and reference reset, plus edge-history stages
  lcr_mask_t  lck_s1, lck_s2, lck_s3, lck_s4, lrst_s1, lrst_s2;
  lcr_lanes_t lwd_s1, lwd_s2;
  logic [2:0] uck_q, rck_q;
  logic [1:0] rrst_q;

  // Clock stages run one deeper than data so the word is stable when taken
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lck_s1  <= MASK_RESET;
      lck_s2  <= MASK_RESET;
      lck_s3  <= MASK_RESET;
      lck_s4  <= MASK_RESET;
      lrst_s1 <= MASK_SET;
      lrst_s2 <= MASK_SET;
      lwd_s1  <= LANES_RESET;
      lwd_s2  <= LANES_RESET;
      uck_q   <= 3'h0;
      rck_q   <= 3'h0;
      rrst_q  <= RST_SYNC_INIT;
    end else begin
      lck_s1  <= rx_lane_recovered_clock_i;
      lck_s2  <= lck_s1;
      lck_s3  <= lck_s2;
      lck_s4  <= lck_s3;
      lrst_s1 <= rx_lane_reset_i;
      lrst_s2 <= lrst_s1;
      lwd_s1  <= rx_lane_word_i;
      lwd_s2  <= lwd_s1;
      uck_q   <= {uck_q[1:0], user_bus_clock_i};
      rck_q   <= {rck_q[1:0], tx_reference_clock_i};
      rrst_q  <= {rrst_q[0], tx_reference_clock_reset_i};
    end
  end

  lcr_mask_t lane_rise, lane_ok;
  logic      user_rise, ref_rise, tx_ok;

  // Rising edges, seen only past the first sampling flop
  assign lane_rise = lck_s3 & ~lck_s4;
  assign user_rise = uck_q[1] & ~uck_q[2];
  assign ref_rise  = rck_q[1] & ~rck_q[2];
  assign lane_ok   = ~lrst_s2 & {LANE_COUNT{~rx_rst_s}};
  assign tx_ok     = ~tx_rst_s & ~rrst_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // Receive capture: one holding word and a pending flag per lane
  lcr_lanes_t hold_q, hold_d;
  lcr_mask_t  pend_q, pend_d, act_q, act_d;
  logic       ovf_q, ovf_d, any_pend, rx_in_ready;
  lcr_idx_t   sel;
  lcr_item_t  rx_item;

  // Lowest pending lane wins; a slow user only costs the older, still pending word
  always_comb begin
    sel      = '0;
    any_pend = 1'b0;
    for (int l = LANE_COUNT - 1; l >= 0; l--) begin
      if (pend_q[l]) begin
        sel      = LANE_IDX_W'(l);
        any_pend = 1'b1;
      end
    end
    hold_d = hold_q;
    pend_d = pend_q;
    ovf_d  = ovf_q & ~rx_rst_s;
    act_d  = lane_ok;
    if (any_pend && rx_in_ready) begin
      pend_d[sel] = 1'b0;
    end
    for (int l = 0; l < LANE_COUNT; l++) begin
      if (!lane_ok[l]) begin
        pend_d[l] = 1'b0;
      end else if (lane_rise[l]) begin
        hold_d[l] = lwd_s2[l];
        if (pend_d[l]) begin
          ovf_d = 1'b1;
        end
        pend_d[l] = 1'b1; // New word beats the grant clear
      end
    end
  end

  // Receive capture registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_q <= LANES_RESET;
      pend_q <= MASK_RESET;
      act_q  <= MASK_RESET;
      ovf_q  <= 1'b0;
    end else begin
      hold_q <= hold_d;
      pend_q <= pend_d;
      act_q  <= act_d;
      ovf_q  <= ovf_d;
    end
  end

  // Receive buffer, drained on user bus clock rises
  lcr_buf2 #(
    .W (RX_ITEM_W)
  ) u_rx_buf (
    .clk_i       (core_clk_i),
    .rst_i       (rst_i),
    .flush_i     (rx_rst_s),
    .in_valid_i  (any_pend),
    .in_ready_o  (rx_in_ready),
    .in_data_i   ({sel, hold_q[sel]}),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i & user_rise),
    .out_data_o  (rx_item)
  );

  assign rx_lane_o = rx_item[RX_ITEM_W-1 -: LANE_IDX_W];
  assign rx_word_o = rx_item[WORD_W-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // Transmit: user group buffered, one group per reference clock rise
  logic       tx_out_v;
  lcr_lanes_t tx_head, txw_q, txw_d;
  logic       stb_q, stb_d;

  // Transmit buffer, filled on user bus clock rises
  lcr_buf2 #(
    .W (LANE_COUNT * WORD_W)
  ) u_tx_buf (
    .clk_i       (core_clk_i),
    .rst_i       (rst_i),
    .flush_i     (tx_rst_s),
    .in_valid_i  (tx_valid_i & user_rise & ~tx_rst_s),
    .in_ready_o  (tx_ready_o),
    .in_data_i   (tx_group_i),
    .out_valid_o (tx_out_v),
    .out_ready_i (ref_rise & tx_ok),
    .out_data_o  (tx_head)
  );

  // Idle words fill any reference edge that finds the buffer empty
  always_comb begin
    txw_d = txw_q;
    stb_d = ref_rise & tx_ok;
    if (!tx_ok) begin
      txw_d = {LANE_COUNT{TX_IDLE_WORD}};
    end else if (ref_rise) begin
      txw_d = tx_out_v ? tx_head : {LANE_COUNT{TX_IDLE_WORD}};
    end
  end

  // Transmit output and status registers
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      txw_q <= LANES_RESET;
      stb_q <= 1'b0;
    end else begin
      txw_q <= txw_d;
      stb_q <= stb_d;
    end
  end

  assign tx_lane_word_o     = txw_q;
  assign tx_lane_strobe_o   = stb_q;
  assign rx_overflow_o      = ovf_q;
  assign rx_lane_active_o   = act_q;
  assign rx_path_in_reset_o = rx_rst_q[1];
  assign tx_path_in_reset_o = tx_rst_q[1];
endmodule

`default_nettype wire

/* verification/lcr_lane_if_chk.sv */
// Port checks for the lane clock and reset block
`timescale 1ns/1ps
`default_nettype none
module lcr_lane_if_chk import lcr_pkg::*; (
  // Clock, resets and stimulus
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       rx_path_reset_i,
  input wire logic       tx_reference_clock_i,
  input wire lcr_mask_t  rx_lane_reset_i,
  input wire logic       rx_ready_i,
  // Block outputs
  input wire lcr_lanes_t tx_lane_word_o,
  input wire logic       tx_lane_strobe_o,
  input wire logic       rx_valid_o,
  input wire lcr_word_t  rx_word_o,
  input wire lcr_mask_t  rx_lane_active_o,
  input wire logic       rx_path_in_reset_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // Path reset enters at once and leaves only after a quiet spell
  rx_set_a: assert property (rx_path_reset_i |=> rx_path_in_reset_o)
    else $error("rx path reset not synchronised");
  rx_rel_a: assert property (
    (!rx_path_reset_i)[*4] |-> !rx_path_in_reset_o)
    else $error("rx path reset stuck");
  // A held lane or a held path never reads as active
  lane_off_a: assert property (
    (rx_lane_active_o & rx_lane_reset_i & $past(rx_lane_reset_i)
     & $past(rx_lane_reset_i, 2) & $past(rx_lane_reset_i, 3)) == '0)
    else $error("held lane shown active");
  path_off_a: assert property (
    rx_path_in_reset_o && $past(rx_path_in_reset_o) |-> rx_lane_active_o == '0)
    else $error("lane active in path reset");
  // Lane words move only with a strobe, or fall back to idle
  tx_word_a: assert property (
    $changed(tx_lane_word_o) |-> tx_lane_strobe_o || tx_lane_word_o == '0)
    else $error("tx word moved without strobe");
  strobe_ref_a: assert property (
    tx_lane_strobe_o |-> $past(tx_reference_clock_i, 3) ##1 !tx_lane_strobe_o)
    else $error("strobe without reference rise");
  // A stalled item stands unchanged unless the path is being reset
  rx_hold_a: assert property (
    rx_valid_o && !rx_ready_i && !rx_path_reset_i && !rx_path_in_reset_o |=>
    rx_path_reset_i || (rx_valid_o && $stable(rx_word_o)))
    else $error("stalled rx item changed");
  rx_src_a: assert property (
    $rose(rx_valid_o) |-> $past(rx_lane_active_o) != '0)
    else $error("rx item with no active lane");
endmodule
bind lcr_lane_if lcr_lane_if_chk lcr_lane_if_chk_inst (.core_clk_i, .rst_i,
  .rx_path_reset_i, .tx_reference_clock_i, .rx_lane_reset_i, .rx_ready_i,
  .tx_lane_word_o, .tx_lane_strobe_o, .rx_valid_o, .rx_word_o,
  .rx_lane_active_o, .rx_path_in_reset_o);
`default_nettype wire

/* verification/lcr_xcvr_model.sv */
// Transceiver-side partner: lane clocks, lane words and tx reference
`timescale 1ns/1ps
`default_nettype none
module lcr_xcvr_model import lcr_pkg::*; (
  // Commands from the bench
  input  wire logic      unlock_i,
  input  wire lcr_mask_t hold_i,
  // Pins toward the block
  output lcr_mask_t      rclk_o,
  output lcr_mask_t      rrst_o,
  output lcr_lanes_t     rword_o,
  output logic           ref_o,
  output logic           ref_rst_o
);
  logic        lclk;
  logic [31:0] cnt;
  ////////////////////////////////////////
  // 320 ns lane clock; word moves 240 ns after a rise, so it is settled
  initial begin
    lclk = 1'b0;
    cnt = '0;
    forever begin
      #80 cnt = cnt + 1;
      #80 lclk = 1'b1;
      #160 lclk = 1'b0;
    end
  end
  assign rclk_o = {LANE_COUNT{lclk}}; // Free running
  assign rrst_o = hold_i; // Held until the lane is ready
  // A lane in reset shows inverted data, never a clean stale word
  always_comb begin
    for (int l = 0; l < LANE_COUNT; l++)
      rword_o[l] = {8'(l), 24'h5A5A5A, cnt} ^ {64{hold_i[l]}};
  end
  // Reference clock at the serializer rate; reset tracks loss of lock
  initial begin
    ref_o = 1'b0;
    #7;
    forever #160 ref_o = ~ref_o;
  end
  assign ref_rst_o = unlock_i;
endmodule
`default_nettype wire

/* verification/lcr_lane_if_tb.sv */
// Self-checking bench for the lane clock and reset block
`timescale 1ns/1ps
`default_nettype none
module lcr_lane_if_tb;
  import lcr_pkg::*;
  logic       core_clk_i, rst_i, rx_path_reset_i, tx_path_reset_i;
  logic       user_bus_clock_i, tx_reference_clock_i, unlock_i;
  logic       tx_reference_clock_reset_i, tx_lane_strobe_o, tx_valid_i;
  logic       tx_ready_o, rx_valid_o, rx_ready_i, rx_overflow_o;
  logic       rx_path_in_reset_o, tx_path_in_reset_o;
  lcr_mask_t  rx_lane_recovered_clock_i, rx_lane_reset_i;
  lcr_mask_t  rx_lane_active_o, hold_i;
  lcr_lanes_t rx_lane_word_i, tx_lane_word_o, tx_group_i;
  lcr_idx_t   rx_lane_o;
  lcr_word_t  rx_word_o;
  int         miscompares = 0;
  int         compares = 0;
  int         cyc = 0;
  lcr_lane_if lcr_lane_if_inst (.core_clk_i, .rst_i, .rx_path_reset_i,
    .tx_path_reset_i, .user_bus_clock_i, .tx_reference_clock_i,
    .tx_reference_clock_reset_i, .rx_lane_recovered_clock_i, .rx_lane_reset_i,
    .rx_lane_word_i, .tx_lane_word_o, .tx_lane_strobe_o, .tx_valid_i,
    .tx_ready_o, .tx_group_i, .rx_valid_o, .rx_ready_i, .rx_lane_o, .rx_word_o,
    .rx_overflow_o, .rx_lane_active_o, .rx_path_in_reset_o,
    .tx_path_in_reset_o);
  lcr_xcvr_model lcr_xcvr_model_inst (.unlock_i, .hold_i,
    .rclk_o(rx_lane_recovered_clock_i), .rrst_o(rx_lane_reset_i),
    .rword_o(rx_lane_word_i), .ref_o(tx_reference_clock_i),
    .ref_rst_o(tx_reference_clock_reset_i));
  ////////////////////////////////////////
  // Core clock 40 ns; user clock 160 ns, offset so no edges coincide
  initial begin
    core_clk_i = 1'b0;
    forever #20 core_clk_i = ~core_clk_i;
  end
  initial begin
    user_bus_clock_i = 1'b0;
    #3;
    forever #80 user_bus_clock_i = ~user_bus_clock_i;
  end
  // Hang guard: the run needs well under 5000 core cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Lane word of group k; top bit set so the first bit on the line is one
  function automatic lcr_lanes_t grp(int k);
    for (int l = 0; l < LANE_COUNT; l++)
      grp[l] = {4'hC, 4'(l), 8'(k), 48'h96A5_0F3C_5A69};
  endfunction
  // Valid spans only the one user rise it is meant for
  task automatic send(int k);
    @(posedge user_bus_clock_i);
    @(posedge core_clk_i);
    tx_group_i <= grp(k);
    tx_valid_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    tx_valid_i <= 1'b0;
  endtask
  // Next strobed group that is not idle, bounded to 60 cycles
  task automatic tx_expect(int k);
    lcr_lanes_t w;
    lcr_lanes_t g;
    g = grp(k);
    w = '0;
    for (int i = 0; i < 60 && w === '0; i++) begin
      @(negedge core_clk_i);
      if (tx_lane_strobe_o === 1'b1)
        w = tx_lane_word_o;
    end
    for (int l = 0; l < LANE_COUNT; l++)
      chk("tx lane word", w[l], g[l]);
  endtask
  task automatic test_tx();
    chk("tx path reset", 64'(tx_path_in_reset_o), 64'h0);
    fork
      send(1);
      tx_expect(1);
    join
    repeat (10) @(negedge core_clk_i);
    chk("tx idle word", tx_lane_word_o[11], TX_IDLE_WORD);
    // Reference out of lock: two groups fill the buffer, a third is refused
    @(posedge core_clk_i);
    unlock_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    send(2);
    send(3);
    repeat (2) @(negedge core_clk_i);
    chk("tx ready full", 64'(tx_ready_o), 64'h0);
    send(4);
    unlock_i <= 1'b0;
    tx_expect(2);
    tx_expect(3);
    repeat (10) @(negedge core_clk_i);
    chk("tx refused group", tx_lane_word_o[0], TX_IDLE_WORD);
    $display("test tx done");
  endtask
  // One live lane; eight words in order with a stall of eight cycles
  task automatic rx_lane(int l);
    lcr_word_t prev;
    int        n;
    prev = '0;
    n = 0;
    @(posedge core_clk_i);
    hold_i <= ~(12'h001 << l);
    for (int i = 0; i < 300 && n < 8; i++) begin
      @(posedge core_clk_i);
      rx_ready_i <= !(i inside {[20:27]});
      @(negedge core_clk_i);
      if (rx_valid_o === 1'b1 && rx_word_o !== prev) begin
        chk("rx lane", 64'(rx_lane_o), 64'(l));
        chk("rx word tag", 64'(rx_word_o[63:56]), 64'(l));
        if (n > 0)
          chk("rx count", 64'(rx_word_o[31:0]), 64'(prev[31:0] + 1));
        prev = rx_word_o;
        n++;
      end
    end
    @(posedge core_clk_i);
    hold_i <= '1;
    repeat (24) @(posedge core_clk_i);
    chk("rx items", 64'(n), 64'd8);
    $display("test rx lane %0d done", l);
  endtask
  // Path reset with an item stalled: flushed, then traffic resumes
  task automatic test_rx_reset();
    @(posedge core_clk_i);
    hold_i <= ~12'h001;
    repeat (30) @(posedge core_clk_i);
    rx_ready_i <= 1'b0;
    repeat (12) @(posedge core_clk_i);
    chk("rx overflow", 64'(rx_overflow_o), 64'h0);
    rx_path_reset_i <= 1'b1;
    repeat (3) @(negedge core_clk_i);
    chk("rx path reset", 64'(rx_path_in_reset_o), 64'h1);
    chk("rx lanes active", 64'(rx_lane_active_o), 64'h0);
    chk("rx flushed", 64'(rx_valid_o), 64'h0);
    @(posedge core_clk_i);
    rx_path_reset_i <= 1'b0;
    rx_ready_i <= 1'b1;
    repeat (4) @(negedge core_clk_i);
    chk("rx path release", 64'(rx_path_in_reset_o), 64'h0);
    rx_lane(0);
  endtask
  // Path resets held while the clocks start
  initial begin
    rst_i = 1'b1;
    rx_path_reset_i = 1'b1;
    tx_path_reset_i = 1'b1;
    tx_valid_i = 1'b0;
    tx_group_i = '0;
    rx_ready_i = 1'b1;
    unlock_i = 1'b0;
    hold_i = '1;
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rx_path_reset_i <= 1'b0;
    tx_path_reset_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    test_tx();
    rx_lane(3);
    rx_lane(11);
    test_rx_reset();
    end_sim();
  end
endmodule
`default_nettype wire
